// ---- ofsc_bench.sv ----
// self-checking bench for the output frame and strobe control block
`timescale 1ns/100ps
module output_frame_strobe_control_bench;
    logic                           pclk, presetn, psel, penable, pwrite;
    logic [11:0]                    paddr;
    logic [31:0]                    pwdata, prdata, rnd, seed;
    logic                           pready, pslverr, bit_clk, vflag_i, arm, flip, done;
    logic [7:0]                     n_str, n_rise;
    ofsc_pkg::ofsc_par_word_t       par_word;
    ofsc_pkg::ofsc_pins_t           pins;
    logic [32:0]                    q_rd[$];
    logic [15:0]                    q_cnt[$];
    int                             err_total, compares, fr;
    ofsc_frame_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_clk(bit_clk), .vflag_i(vflag_i), .par_word(par_word),
        .pins(pins));
    ofsc_rx_model rx (.arm(arm), .flip(flip), .pins(pins), .bit_clk(bit_clk),
        .vflag_i(vflag_i), .done(done), .n_str(n_str), .n_rise(n_rise));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // apb master: hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        if (n >= 50) begin
            err_total++;
            finish_test();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q_rd.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask
    // stop the port, load the frame fields, then start it with the wanted mode
    task automatic cfg(input logic [1:0] m, input logic mst, input logic fp,
                       input logic [5:0] fl, input logic [1:0] pat);
        flip <= fp;
        apb(1'h1, ofsc_pkg::MODE_CTRL_ADDR, {27'h0, 1'h0, fp, mst, m});
        apb(1'h1, ofsc_pkg::FRAME_CTRL_ADDR, {24'h0, pat, fl});
        apb(1'h1, ofsc_pkg::WORD_CTRL_ADDR, 32'h00000303);  // 4 ticks a word, 4 own words
        apb(1'h1, ofsc_pkg::MODE_CTRL_ADDR, {27'h0, 1'h1, fp, mst, m});
        repeat (160) @(posedge pclk);
    endtask
    task automatic start(input logic [7:0] s, input logic [7:0] r);
        q_cnt.push_back({s, r});
        @(posedge pclk);
        arm <= 1'h1;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (!done && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
            finish_test();
        end
        arm <= 1'h0;
        repeat (12) @(posedge pclk);
    endtask
    task automatic offer(input logic q, input logic f);
        par_word <= {1'h1, q, f};
        @(posedge pclk);
        par_word <= '0;
        repeat (15) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // result watchers: oldest note against what appears
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk("apb read", q_rd.pop_front(), {pslverr, prdata});
    end
    always @(posedge done) begin
        chk("strobe count", {25'h0, q_cnt[0][15:8]}, {25'h0, n_str});
        if (q_cnt[0][7:0] !== 8'hFF) chk("flag rises", {25'h0, q_cnt[0][7:0]}, {25'h0, n_rise});
        void'(q_cnt.pop_front());
    end
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, arm, flip} = '0;
        {paddr, pwdata, par_word, err_total, compares} = '0;
        seed = 32'h0000ACF2;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd(ofsc_pkg::FRAME_CTRL_ADDR, {25'h0, ofsc_pkg::FRAME_CTRL_RST});
        rd(ofsc_pkg::MODE_CTRL_ADDR, {28'h0, ofsc_pkg::MODE_CTRL_RST});
        rd(ofsc_pkg::WORD_CTRL_ADDR, {22'h0, ofsc_pkg::WORD_CTRL_RST});
        rd(12'h0FC, {1'h1, 32'h0});
        rd(ofsc_pkg::STATUS_ADDR, {1'h0, 32'h00080000});  // only the flag drive is up after reset
        rnd = $random(seed);
        apb(1'h1, ofsc_pkg::FRAME_CTRL_ADDR, rnd);
        rd(ofsc_pkg::FRAME_CTRL_ADDR, {25'h0, rnd[7:0]});
        $display("register test done");
        // serial and nibble: frame length fields 3, 7 and 15, every strobe pattern, primary chip
        for (int m = 1; m <= 2; m++) begin
            for (int f = 3; f <= 15; f = f * 2 + 1) begin
                for (int p = 0; p < 4; p++) begin
                    fr = 16 / (f + 1);
                    cfg(m[1:0], 1'h1, 1'h0, f[5:0], p[1:0]);
                    chk("flag enable", 33'h1, {32'h0, pins.vflag_oe});
                    start(8'(p == 3 ? fr * 4 : p == 1 ? fr * 2 : fr), 8'(fr));
                    wait_done();
                end
            end
        end
        $display("serial and nibble test done");
        cfg(2'h1, 1'h1, 1'h1, 6'h03, 2'h3);
        start(8'h10, 8'h04);
        wait_done();
        $display("polarity test done");
        // parallel: I and Q offers, block of two complex samples
        for (int p = 0; p < 4; p++) begin
            cfg(2'h3, 1'h1, 1'h0, 6'h00, p[1:0]);
            start(8'(p < 2 ? 4 : 8), 8'(p < 2 ? 4 : 2));
            for (int i = 0; i < 8; i++) offer(i[0], i % 4 == 0 && rnd[0] | !rnd[0]);
            wait_done();
        end
        $display("parallel test done");
        cfg(2'h0, 1'h1, 1'h0, 6'h00, 2'h0);
        start(8'h00, 8'hFF);
        wait_done();
        // secondary: frame mark every 16 ticks, own words 1..3 after a one-word delay
        cfg(2'h1, 1'h0, 1'h0, 6'h00, 2'h0);
        chk("flag enable", 33'h0, {32'h0, pins.vflag_oe});
        start(8'h04, 8'h00);
        wait_done();
        $display("micro and secondary test done");
        finish_test();
    end
endmodule // output_frame_strobe_control_bench

// ---- ofsc_frame_ctrl.sv ----
// output frame length, time-slot placement and strobe generation with apb registers
//
// How it works
// - serial and nibble frames last frame length plus one single words
// - primary chip frame is length plus one, its words in first slots
// - secondary chip waits length plus one words after frame start
// - serial strobe lasts one bit clock just before the marked word
// - serial pattern 0 or 2 strobes only before the first own word of a frame
// - serial pattern 1 strobes before every in-phase word only
// - serial pattern 3 strobes before every own word
// - nibble strobe follows serial patterns but coincides with first nibble
// - parallel pattern 0/1: strobe on in-phase, valid flag on quadrature
// - parallel pattern 2/3: strobe on every valid word
// - parallel pattern 2/3: valid flag marks first in-phase word of block
// - that flag rises after last frame word, falls after first next word
// - mode selector: 0 micro, 1 serial, 2 nibble/link, 3 parallel
// - valid flag pin driven when primary, sampled when secondary
// - frame strobe active high unless polarity flip is set
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module ofsc_frame_ctrl (
    input  wire logic                    pclk,       // block clock, 250 MHz
    input  wire logic                    presetn,    // asynchronous reset, active low
    input  wire logic                    psel,       // apb select
    input  wire logic                    penable,    // apb access phase
    input  wire logic                    pwrite,     // apb write
    input  wire logic [11:0]             paddr,      // apb byte address
    input  wire logic [31:0]             pwdata,     // apb write data
    output logic      [31:0]             prdata,     // apb read data
    output logic                         pready,     // apb ready
    output logic                         pslverr,    // apb error, unmapped address
    input  wire logic                    bit_clk,    // output bit clock, asynchronous
    input  wire logic                    vflag_i,    // valid flag pin, input side
    input  ofsc_pkg::ofsc_par_word_t     par_word,   // parallel sample offer, pclk domain
    output ofsc_pkg::ofsc_pins_t         pins        // strobe, flag and slot pins
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  frame_ctrl_r;
    logic [4:0]  mode_ctrl_r;
    logic [10:0] word_ctrl_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic        hit;
    logic        acc;
    logic        done;
    logic [5:0]  bcnt_r;
    logic [6:0]  wcnt_r;

    logic [5:0]  fl;
    logic [1:0]  sps;
    logic [5:0]  wc;
    logic [2:0]  slots;
    logic        master;
    logic        flip;
    logic        enable;
    ofsc_pkg::ofsc_mode_t mode;

    assign fl     = frame_ctrl_r[ofsc_pkg::FL_LSB +: ofsc_pkg::FL_W];
    assign sps    = frame_ctrl_r[ofsc_pkg::SPS_LSB +: ofsc_pkg::SPS_W];
    assign wc     = word_ctrl_r[ofsc_pkg::WC_LSB +: ofsc_pkg::WC_W];
    assign slots  = word_ctrl_r[ofsc_pkg::SLOTS_LSB +: ofsc_pkg::SLOTS_W];
    assign master = mode_ctrl_r[ofsc_pkg::MASTER_BIT];
    assign flip   = mode_ctrl_r[ofsc_pkg::FLIP_BIT];
    assign enable = mode_ctrl_r[ofsc_pkg::ENABLE_BIT];
    assign mode   = ofsc_pkg::ofsc_mode_t'(mode_ctrl_r[ofsc_pkg::OM_LSB +: 2]);

    // apb phases: acc is the first access cycle, done the completing edge
    assign acc  = psel & penable & ~pready_r;
    assign done = psel & penable & pready_r;

    // read data and address decode
    always_comb begin
        hit    = 1'b1;
        rd_nxt = ofsc_pkg::READ_ZERO;
        unique case (paddr)
            ofsc_pkg::FRAME_CTRL_ADDR: rd_nxt = {24'h000000, frame_ctrl_r};
            ofsc_pkg::MODE_CTRL_ADDR:  rd_nxt = {27'h0000000, mode_ctrl_r};
            ofsc_pkg::WORD_CTRL_ADDR:  rd_nxt = {21'h000000, word_ctrl_r};
            ofsc_pkg::STATUS_ADDR:     rd_nxt = {10'h000, pins, 5'h00, wcnt_r, bcnt_r};
            default:                   hit    = 1'b0;
        endcase
    end

    // apb handshake: one wait state, answer flopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= ofsc_pkg::READ_ZERO;
        end else begin
            pready_r  <= acc;
            pslverr_r <= acc & ~hit;
            prdata_r  <= (acc & ~pwrite & hit) ? rd_nxt : ofsc_pkg::READ_ZERO;
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_ctrl_r <= ofsc_pkg::FRAME_CTRL_RST;
            mode_ctrl_r  <= ofsc_pkg::MODE_CTRL_RST;
            word_ctrl_r  <= ofsc_pkg::WORD_CTRL_RST;
        end else if (done & pwrite) begin
            if (paddr == ofsc_pkg::FRAME_CTRL_ADDR) frame_ctrl_r <= pwdata[7:0];
            if (paddr == ofsc_pkg::MODE_CTRL_ADDR)  mode_ctrl_r  <= pwdata[4:0];
            if (paddr == ofsc_pkg::WORD_CTRL_ADDR)  word_ctrl_r  <= pwdata[10:0];
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bit clock and valid flag input crossing
    logic [1:0] sync_q;
    logic       bclk_s;
    logic       bclk_d_r;
    logic       vflag_s;
    logic       vflag_d_r;
    logic       tick;

    ofsc_sync2 #(.W(2)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({bit_clk, vflag_i}),
        .q     (sync_q)
    );
    assign bclk_s  = sync_q[1];
    assign vflag_s = sync_q[0];
    assign tick    = bclk_s & ~bclk_d_r;   // rising bit clock edge

    // edge detect history and pending frame start seen from the primary chip
    logic sof_pend_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_d_r   <= 1'b0;
            vflag_d_r  <= 1'b0;
            sof_pend_r <= 1'b0;
        end else begin
            bclk_d_r  <= bclk_s;
            vflag_d_r <= vflag_s;
            // a new rise wins over the clear at the tick
            if (~master & vflag_s & ~vflag_d_r) sof_pend_r <= 1'b1;
            else if (tick)                      sof_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word and bit counters for serial and nibble modes
    logic [5:0] bcnt_nxt;
    logic [6:0] wcnt_nxt;
    logic [6:0] fw;
    logic       serial_like;
    logic [6:0] fl_w;

    assign serial_like = enable & (mode == ofsc_pkg::OM_SERIAL | mode == ofsc_pkg::OM_NIBBLE);
    assign fl_w        = {1'b0, fl};

    // own slot test and pattern choice for one word index
    function automatic logic marked(input logic [6:0] idx, input logic prim,
                                    input logic [6:0] len, input logic [2:0] sl,
                                    input logic [1:0] pat);
        logic [6:0] k;
        logic       own;
        k   = prim ? idx : 7'(idx - len - 7'h01);
        own = prim ? (idx <= {4'h0, sl})
                   : (idx > len) & (k <= {4'h0, sl});
        unique case (pat)
            2'h1:    marked = own & ~k[0];
            2'h3:    marked = own;
            default: marked = own & (k == 7'h00);
        endcase
    endfunction

    // next counter state at a bit clock edge
    always_comb begin
        bcnt_nxt = bcnt_r;
        wcnt_nxt = wcnt_r;
        if (~serial_like) begin
            bcnt_nxt = 6'h00;
            wcnt_nxt = 7'h00;
        end else if (tick) begin
            if (~master & sof_pend_r) begin
                bcnt_nxt = 6'h00;
                wcnt_nxt = 7'h00;
            end else if (bcnt_r == wc) begin
                bcnt_nxt = 6'h00;
                if (master) wcnt_nxt = (wcnt_r == fl_w) ? 7'h00 : 7'(wcnt_r + 7'h01);
                else if (wcnt_r != 7'h7F) wcnt_nxt = 7'(wcnt_r + 7'h01);
            end else begin
                bcnt_nxt = 6'(bcnt_r + 6'h01);
            end
        end
        // word that follows the one being sent
        fw = master ? ((wcnt_nxt == fl_w) ? 7'h00 : 7'(wcnt_nxt + 7'h01))
                    : 7'(wcnt_nxt + 7'h01);
    end

    // counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_r <= 6'h00;
            wcnt_r <= 7'h00;
        end else begin
            bcnt_r <= bcnt_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // parallel mode sample holding until the next bit clock edge
    logic par_pend_r;
    logic par_q_r;
    logic par_first_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_pend_r  <= 1'b0;
            par_q_r     <= 1'b0;
            par_first_r <= 1'b0;
        end else if (par_word.valid) begin
            // a new offer wins over the clear at the tick
            par_pend_r  <= 1'b1;
            par_q_r     <= par_word.is_q;
            par_first_r <= par_word.first;
        end else if (tick) begin
            par_pend_r  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // strobe and flag generation, updated at bit clock edges, or every cycle while disabled
    logic strobe_raw_r;
    logic strobe_raw_nxt;
    logic vflag_raw_r;
    logic vflag_raw_nxt;
    logic drive_nxt;
    logic par_on;

    assign par_on = enable & (mode == ofsc_pkg::OM_PARALLEL);

    always_comb begin
        strobe_raw_nxt = 1'b0;
        vflag_raw_nxt  = 1'b0;
        drive_nxt      = 1'b0;
        if (mode == ofsc_pkg::OM_SERIAL && serial_like) begin
            strobe_raw_nxt = (bcnt_nxt == wc) & marked(fw, master, fl_w, slots, sps);
            vflag_raw_nxt  = (wcnt_nxt == 7'h00);
            drive_nxt      = marked(wcnt_nxt, master, fl_w, slots, 2'h3);
        end else if (mode == ofsc_pkg::OM_NIBBLE && serial_like) begin
            strobe_raw_nxt = (bcnt_nxt == 6'h00) & marked(wcnt_nxt, master, fl_w, slots, sps);
            vflag_raw_nxt  = (wcnt_nxt == 7'h00);
            drive_nxt      = marked(wcnt_nxt, master, fl_w, slots, 2'h3);
        end else if (par_on && par_pend_r) begin
            drive_nxt = 1'b1;
            if (~sps[1]) begin
                strobe_raw_nxt = ~par_q_r;
                vflag_raw_nxt  = par_q_r;
            end else begin
                strobe_raw_nxt = 1'b1;
                vflag_raw_nxt  = par_first_r;
            end
        end else if (par_on && sps[1]) begin
            vflag_raw_nxt = vflag_raw_r;
        end
    end

    // pin flops; strobe, flag and slot drive changes land on the bit clock edge that moves the data, vflag_oe follows master every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_raw_r <= 1'b0;
            vflag_raw_r  <= 1'b0;
            pins         <= '0;
        end else begin
            pins.vflag_oe <= master;
            if (tick | ~enable) begin
                strobe_raw_r      <= strobe_raw_nxt & enable;
                vflag_raw_r       <= vflag_raw_nxt & enable;
                pins.frame_strobe <= (strobe_raw_nxt & enable) ^ flip;
                pins.vflag_o      <= vflag_raw_nxt & enable & master;
                pins.slot_drive   <= drive_nxt & enable;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_apb_answer_once: assert property (@(posedge pclk) disable iff (!presetn)
        acc |=> pready ##1 !pready)
        else $error("apb answer not one cycle after access");
    a_strobe_tick_align: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && enable && $past(enable)) |=> $stable(strobe_raw_r))
        else $error("strobe changed away from a bit clock edge");
    a_pin_polarity_flip: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> pins.frame_strobe == (strobe_raw_r ^ $past(flip)))
        else $error("strobe pin polarity wrong");
    a_frame_wrap_len: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_like && master && tick && !sof_pend_r && bcnt_r == wc && wcnt_r == fl_w)
        |=> wcnt_r == 7'h00)
        else $error("frame did not wrap at frame length");
    a_word_bit_count: assert property (@(posedge pclk) disable iff (!presetn)
        (serial_like && tick && !sof_pend_r && bcnt_r < wc && $stable(word_ctrl_r))
        |=> bcnt_r == 6'($past(bcnt_r) + 6'h01))
        else $error("bit counter did not advance");
    a_serial_strobe_lead: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == ofsc_pkg::OM_SERIAL && serial_like && tick && strobe_raw_nxt)
        |=> bcnt_r == $past(wc))
        else $error("serial strobe not in cycle before first bit");
    a_nibble_strobe_with: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == ofsc_pkg::OM_NIBBLE && tick && strobe_raw_nxt) |=> bcnt_r == 6'h00)
        else $error("nibble strobe not with first nibble");
    a_par_q_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (par_on && !sps[1] && tick && par_pend_r && par_q_r) |=> vflag_raw_r && !strobe_raw_r)
        else $error("quadrature word not flagged on valid flag");
    a_par_every_word: assert property (@(posedge pclk) disable iff (!presetn)
        (par_on && sps[1] && tick && par_pend_r) |=> strobe_raw_r)
        else $error("parallel word missed its strobe");
    a_micro_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == ofsc_pkg::OM_MICRO && tick) |=> !strobe_raw_r)
        else $error("strobe in microprocessor mode");
    a_slave_slot_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (!master && serial_like && pins.slot_drive && $stable(frame_ctrl_r)) |-> wcnt_r > fl_w)
        else $error("secondary chip drove before its delay");
endmodule // ofsc_frame_ctrl

// ---- ofsc_pkg.sv ----
// constants and carrier types for the output frame and strobe control block
package ofsc_pkg;
    // register map (byte addresses, one aligned 32-bit word each)
    localparam logic [11:0] FRAME_CTRL_IDX  = 12'h013;
    localparam logic [11:0] FRAME_CTRL_ADDR = 12'h04C;  // four times the index
    localparam logic [11:0] MODE_CTRL_ADDR  = 12'h040;
    localparam logic [11:0] WORD_CTRL_ADDR  = 12'h044;
    localparam logic [11:0] STATUS_ADDR     = 12'h050;

    // output_frame_control fields
    localparam int FL_LSB  = 0;   // frame length minus one, 6 bits
    localparam int FL_W    = 6;
    localparam int SPS_LSB = 6;   // strobe_pattern_select, 2 bits
    localparam int SPS_W   = 2;

    // mode control fields
    localparam int OM_LSB     = 0;   // output mode selector, 2 bits
    localparam int MASTER_BIT = 2;   // primary chip, drives the valid flag
    localparam int FLIP_BIT   = 3;   // strobe_polarity_flip
    localparam int ENABLE_BIT = 4;   // output port running

    // word control fields
    localparam int WC_LSB    = 0;   // bit-clock cycles per word minus one
    localparam int WC_W      = 6;
    localparam int SLOTS_LSB = 8;   // own words per frame minus one
    localparam int SLOTS_W   = 3;

    // reset values
    localparam logic [7:0]  FRAME_CTRL_RST = 8'h00;
    localparam logic [4:0]  MODE_CTRL_RST  = 5'h04;
    localparam logic [10:0] WORD_CTRL_RST  = 11'h017;
    localparam logic [31:0] READ_ZERO      = 32'h00000000;

    // output mode selector, in selector order
    typedef enum logic [1:0] {
        OM_MICRO,
        OM_SERIAL,
        OM_NIBBLE,
        OM_PARALLEL
    } ofsc_mode_t;

    // one parallel sample offered by the data path
    typedef struct packed {
        logic valid;     // one-cycle offer
        logic is_q;      // quadrature word
        logic first;     // first in-phase word of an output block
    } ofsc_par_word_t;

    // strobe and flag pins
    typedef struct packed {
        logic frame_strobe;
        logic vflag_o;
        logic vflag_oe;
        logic slot_drive;
    } ofsc_pins_t;
endpackage

// ---- ofsc_rx_model.sv ----
// downstream receiver model: makes the bit clock and frame mark, counts strobes and flags
`timescale 1ns/100ps
module ofsc_rx_model (
    input  wire logic            arm,      // count window request
    input  wire logic            flip,     // strobe polarity in use
    input  ofsc_pkg::ofsc_pins_t pins,     // strobe and flag pins of the block
    output logic                 bit_clk,  // output bit clock, free running
    output logic                 vflag_i,  // frame mark as a primary chip would give it
    output logic                 done,     // window finished, counts settled
    output logic [7:0]           n_str,    // ticks with the strobe active
    output logic [7:0]           n_rise    // rising edges of the valid flag
);
    logic [6:0] k;
    logic [3:0] ph;
    logic       prev;
    // free running bit clock, 32 ns period, unrelated in phase to pclk
    initial begin
        {k, ph, prev, done, n_str, n_rise, vflag_i} = '0;
        bit_clk = 1'h0;
        #5.3;
        forever #16 bit_clk = ~bit_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // pins settle mid bit clock, so they are sampled on its rising edge
    always @(posedge bit_clk) begin
        ph <= ph + 4'h1;
        vflag_i <= (ph == 4'h0);  // one-tick frame mark every 16 ticks
        prev <= pins.vflag_o;
        done <= 1'h0;
        if (!arm) begin
            k <= '0;
            n_str <= '0;
            n_rise <= '0;
        end else if (k < 7'h40) begin
            k <= k + 7'h01;
            n_str <= n_str + {7'h00, pins.frame_strobe ^ flip};
            n_rise <= n_rise + {7'h00, pins.vflag_o & ~prev};
            done <= (k == 7'h3F);
        end
    end
endmodule // ofsc_rx_model

// ---- ofsc_sync2.sv ----
// two-flop synchroniser for inputs arriving from outside pclk
`timescale 1ns/100ps
module ofsc_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,      // sampling clock
    input  wire logic         rst_n,    // asynchronous reset, active low
    input  wire logic [W-1:0] d,        // asynchronous inputs
    output logic      [W-1:0] q         // synchronised outputs
);
    logic [W-1:0] meta_r;

    // one pair of flops per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else begin
                    meta_r[i] <= d[i];
                    q[i]      <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule // ofsc_sync2
